/* File: logic/cmd_word_map.vh */
// command word field positions, control-place code and timing constants
// assumes inclusion by bare name from the decoder module
`ifndef CMD_WORD_MAP_VH
`define CMD_WORD_MAP_VH
`define CW_SWITCH_ON 0
`define CW_COAST_N 1
`define CW_QSTOP_N 2
`define CW_START 3
`define CW_RAMP_OUT 4
`define CW_RAMP_HOLD 5
`define CW_SETPOINT 6
`define CW_FAULT_ACK 7
`define CW_INCH1 8
`define CW_INCH2 9
`define CW_FB_EN 10
`define CW_WDOG 11
`define CW_RESET 12'h000
`define PLACE_FIELDBUS 2'h3
`define TICK_MS 1
`define CLK_MHZ 200
`define TICK_CYCLES (`TICK_MS * `CLK_MHZ * 1000)
`define ST_INHIBIT 3'h0
`define ST_READY_ON 3'h1
`define ST_READY_RUN 3'h2
`define ST_RUN 3'h3
`define ST_RAMP_STOP 3'h4
`define ST_COAST 3'h5
`define ST_QSTOP 3'h6
`define ST_FAULT 3'h7
`endif

/* File: logic/fieldbus_control_word_decoder.v */
// fieldbus main command word decoder for a motor drive sequencer
// assumes the word arrives on the same clock; motor status inputs are synchronous
//
// How it works
// RL1: switch-on rising edge leaves inhibit, ready-to-run
// RL2: switch-on low ramps down to ready-on
// RL3: coast bit low coasts into inhibit
// RL4: quick-stop low runs configured quick stop
// RL5: start bit runs, low stops by function
// RL6: ramp-output low zeroes ramp, overrides others
// RL7: ramp-hold low freezes speed, ignore references
// RL8: setpoint low zeroes reference, lowest priority
// RL9: fault acknowledged on rising edge, inhibit after; code enters ready-on instead unless fault_removed_voltage is set
// RL10: inching bits jog when separately enabled
// RL11: fieldbus jog: start, ramp bits zero, stopped
// RL12: ramp bits honoured again after zero speed
// RL13: start disables inching; both inching stops; code requires the start bit for a jog
// RL14: enable bit only counts at fieldbus place
// RL15: enable withdrawn while running coasts
// RL16: master toggles watchdog about once a second
// RL17: missing watchdog faults; zero delay disables
// RL18: watchdog bit echoed to status top bit
// RL19: top four bits ignored
`timescale 1ns/1ps
`include "cmd_word_map.vh"
module fieldbus_control_word_decoder #(
  parameter TICK_CYCLES = `TICK_CYCLES,
  parameter WD_W = 16
)(
  input wire clk_sys,
  input wire sys_rst,
  input wire [15:0] command_word,
  input wire command_word_valid,
  input wire [1:0] control_place_selection,
  input wire [WD_W-1:0] watchdog_delay_setting,
  input wire jog_enable,
  input wire zero_speed,
  input wire fault_active,
  input wire fault_removed_voltage,
  input wire quick_stop_coasts,
  output reg [2:0] drive_state_ff,
  output reg run_cmd_ff,
  output reg coast_stop_ff,
  output reg ramp_stop_ff,
  output reg quick_stop_ff,
  output reg ramp_out_zero_ff,
  output reg ramp_hold_ff,
  output reg ref_zero_ff,
  output reg jog1_ff,
  output reg jog2_ff,
  output reg fault_ack_ff,
  output reg fb_comm_fault_ff,
  output reg wd_echo_ff
);
  // latched word, reserved top bits masked
  // only bits 0-11 carry meaning, so only they are stored
  reg [11:0] cw_ff;
  // next value of the latched word
  reg [11:0] nxt_cw;
  // word one cycle older, for edge detection
  // resets to zero so a bit held high at release still counts as a rise
  reg [11:0] prev_cw_ff;
  // tick counter and watchdog timer
  // free running divider, one pulse per millisecond
  reg [31:0] tick_cnt_ff;
  // one cycle tick pulse
  reg tick_ff;
  // ticks seen since the last watchdog bit change
  reg [WD_W-1:0] wd_cnt_ff;
  // watchdog bit one cycle back
  reg wd_prev_ff;
  // jog latch across zero speed
  // holds the ramp bits off until the motor is back at standstill
  reg jog_active_ff;
  // next drive state
  reg [2:0] nxt_state;

  // accepted word fields
  // the word only steers the state, jog and acknowledge at the fieldbus control place
  // and with its own enable bit set; the ramp bits act at any place
  wire fb_place = (control_place_selection == `PLACE_FIELDBUS);
  wire fb_ctrl = fb_place & cw_ff[`CW_FB_EN]; // RL14
  // switch-on rising edge, leaves inhibit
  wire on_rise = cw_ff[`CW_SWITCH_ON] & ~prev_cw_ff[`CW_SWITCH_ON];
  // fault acknowledge rising edge, one cycle
  wire ack_rise = cw_ff[`CW_FAULT_ACK] & ~prev_cw_ff[`CW_FAULT_ACK];
  wire ramp_bits_zero = ~cw_ff[`CW_RAMP_OUT] & ~cw_ff[`CW_RAMP_HOLD] & ~cw_ff[`CW_SETPOINT];
  // any inching bit, and the forbidden pair
  wire inch_any = cw_ff[`CW_INCH1] | cw_ff[`CW_INCH2];
  wire inch_both = cw_ff[`CW_INCH1] & cw_ff[`CW_INCH2];
  // fieldbus jog request: start with all ramp bits low
  wire jog_req = fb_ctrl & jog_enable & cw_ff[`CW_START] & ramp_bits_zero
    & inch_any & ~inch_both; // RL11 RL13
  // drive modulating
  wire running = (drive_state_ff == `ST_RUN);
  // enable bit falls while running at the fieldbus place
  wire fb_drop = running & prev_cw_ff[`CW_FB_EN] & fb_place & ~cw_ff[`CW_FB_EN];

  // capture word, bits 12-15 dropped
  always @*
  begin
    nxt_cw = cw_ff;
    // a valid strobe loads the word; without it the last word is held
    if (command_word_valid)
    begin
      nxt_cw = command_word[11:0]; // RL19
    end
  end

  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      cw_ff <= `CW_RESET;
      prev_cw_ff <= `CW_RESET;
    end
    else
    begin
      cw_ff <= nxt_cw;
      prev_cw_ff <= cw_ff;
    end
  end

  // evaluation tick for watchdog delay, in milliseconds
  // the count is a parameter so a bench can shorten the millisecond
  // the counter wraps one short of the count, so the period is exact
  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      tick_cnt_ff <= 32'h00000000;
      tick_ff <= 1'b0;
    end
    else if (tick_cnt_ff == TICK_CYCLES - 1)
    begin
      tick_cnt_ff <= 32'h00000000;
      tick_ff <= 1'b1;
    end
    else
    begin
      tick_cnt_ff <= tick_cnt_ff + 32'h00000001;
      tick_ff <= 1'b0;
    end
  end

  // watchdog: any edge of the bit restarts the timer
  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      wd_cnt_ff <= {WD_W{1'b0}};
      wd_prev_ff <= 1'b0;
      fb_comm_fault_ff <= 1'b0;
      wd_echo_ff <= 1'b0;
    end
    else
    begin
      wd_prev_ff <= cw_ff[`CW_WDOG];
      // echo follows the latched bit, one cycle behind
      wd_echo_ff <= cw_ff[`CW_WDOG]; // RL18
      if (watchdog_delay_setting == {WD_W{1'b0}} || !fb_ctrl)
      begin
        // monitoring off
        wd_cnt_ff <= {WD_W{1'b0}}; // RL17
      end
      else if (wd_prev_ff != cw_ff[`CW_WDOG])
      begin
        // pulse seen
        wd_cnt_ff <= {WD_W{1'b0}};
      end
      // the counter saturates at the delay, so it never wraps to zero
      else if (tick_ff && wd_cnt_ff < watchdog_delay_setting)
      begin
        wd_cnt_ff <= wd_cnt_ff + {{(WD_W-1){1'b0}}, 1'b1};
      end
      // fault set wins over acknowledge
      if (watchdog_delay_setting != {WD_W{1'b0}} && fb_ctrl
          && wd_cnt_ff >= watchdog_delay_setting)
      begin
        fb_comm_fault_ff <= 1'b1; // RL17
      end
      // clearing needs the word to count, so a foreign place cannot clear
      else if (ack_rise && fb_ctrl)
      begin
        fb_comm_fault_ff <= 1'b0; // RL9
      end
    end
  end

  // drive sequencer next state
  always @*
  begin
    nxt_state = drive_state_ff;
    // faults first, then loss of control, then the word's own bits
    if (fault_active || fb_comm_fault_ff)
    begin
      nxt_state = `ST_FAULT;
    end
    else if (fb_drop)
    begin
      // control taken away mid-run
      nxt_state = `ST_COAST; // RL15
    end
    else if (drive_state_ff == `ST_COAST)
    begin
      // coasting ends in inhibit even when the word no longer counts
      nxt_state = `ST_INHIBIT; // RL3 RL15
    end
    else if (fb_ctrl)
    begin
      case (drive_state_ff)
        `ST_FAULT:
        begin
          // acknowledged fault
          // voltage removed by the fault reaction means inhibit
          if (ack_rise)
          begin
            nxt_state = fault_removed_voltage ? `ST_INHIBIT : `ST_READY_ON; // RL9
          end
        end
        `ST_COAST:
        begin
          nxt_state = `ST_INHIBIT; // RL3
        end
        `ST_INHIBIT:
        begin
          // needs coast and quick stop both released in the cycle the edge is seen
          if (on_rise && cw_ff[`CW_COAST_N] && cw_ff[`CW_QSTOP_N])
          begin
            nxt_state = `ST_READY_RUN; // RL1
          end
        end
        default:
        begin
          if (!cw_ff[`CW_COAST_N])
          begin
            // coast overrides every other stop
            nxt_state = `ST_COAST; // RL3
          end
          else if (drive_state_ff == `ST_QSTOP)
          begin
            // quick stop ends in inhibit at standstill, bit low or not
            // the master must pulse switch-on again to leave inhibit
            nxt_state = zero_speed ? `ST_INHIBIT : `ST_QSTOP; // RL4
          end
          else if (!cw_ff[`CW_QSTOP_N])
          begin
            // quick stop request from any powered state
            nxt_state = `ST_QSTOP; // RL4
          end
          else if (!cw_ff[`CW_SWITCH_ON])
          begin
            // switch-on low: ramp down, ready-on once stopped
            nxt_state = zero_speed ? `ST_READY_ON : `ST_RAMP_STOP; // RL2
          end
          else if (drive_state_ff == `ST_READY_ON || drive_state_ff == `ST_RAMP_STOP)
          begin
            nxt_state = `ST_READY_RUN;
          end
          else if (cw_ff[`CW_START] && !inch_both)
          begin
            // start runs unless both inching bits are set
            nxt_state = `ST_RUN; // RL5 RL13
          end
          else
          begin
            // start low: back to ready-to-run by the stop function
            nxt_state = `ST_READY_RUN; // RL5
          end
        end
      endcase
    end
  end

  // state register and decoded actions
  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      // safe start: ramp and reference forced to zero
      drive_state_ff <= `ST_INHIBIT;
      run_cmd_ff <= 1'b0;
      coast_stop_ff <= 1'b0;
      ramp_stop_ff <= 1'b0;
      quick_stop_ff <= 1'b0;
      ramp_out_zero_ff <= 1'b1;
      ramp_hold_ff <= 1'b0;
      ref_zero_ff <= 1'b1;
      jog1_ff <= 1'b0;
      jog2_ff <= 1'b0;
      fault_ack_ff <= 1'b0;
      jog_active_ff <= 1'b0;
    end
    else
    begin
      drive_state_ff <= nxt_state;
      // run flag mirrors the next state so it lines up with the state
      run_cmd_ff <= (nxt_state == `ST_RUN);
      // coast pulse also covers the enable drop cycle
      coast_stop_ff <= (nxt_state == `ST_COAST) | fb_drop; // RL3 RL15
      ramp_stop_ff <= (nxt_state == `ST_RAMP_STOP); // RL2
      // quick stop flag is off when the configured quick stop is a coast
      quick_stop_ff <= (nxt_state == `ST_QSTOP) & ~quick_stop_coasts; // RL4
      // acknowledge is a single cycle pulse
      fault_ack_ff <= ack_rise & fb_ctrl; // RL9
      // jog starts only from standstill, holds until standstill
      if (jog_req && (zero_speed || jog_active_ff) && nxt_state == `ST_RUN)
      begin
        jog_active_ff <= 1'b1; // RL11
      end
      else if (zero_speed)
      begin
        jog_active_ff <= 1'b0; // RL12
      end
      // each reference follows its own inching bit
      jog1_ff <= jog_req & (zero_speed | jog_active_ff) & cw_ff[`CW_INCH1]
        & (nxt_state == `ST_RUN); // RL10
      jog2_ff <= jog_req & (zero_speed | jog_active_ff) & cw_ff[`CW_INCH2]
        & (nxt_state == `ST_RUN); // RL10
      if (jog_active_ff || jog_req)
      begin
        // ramp bits masked while jogging or until standstill
        ramp_out_zero_ff <= 1'b0; // RL12
        ramp_hold_ff <= 1'b0;
        ref_zero_ff <= 1'b0;
      end
      else if (!cw_ff[`CW_RAMP_OUT])
      begin
        // highest priority ramp control
        ramp_out_zero_ff <= 1'b1; // RL6
        ramp_hold_ff <= 1'b0;
        ref_zero_ff <= 1'b0;
      end
      // freeze: hold present speed, new references ignored
      else if (!cw_ff[`CW_RAMP_HOLD])
      begin
        ramp_out_zero_ff <= 1'b0;
        ramp_hold_ff <= 1'b1; // RL7
        ref_zero_ff <= 1'b0;
      end
      else
      begin
        ramp_out_zero_ff <= 1'b0;
        ramp_hold_ff <= 1'b0;
        // lowest priority: setpoint low forces reference to zero
        ref_zero_ff <= ~cw_ff[`CW_SETPOINT]; // RL8
      end
    end
  end
endmodule

/* File: verification/fcw_checker_assertions.sv */
// port checker for the command word decoder
// assumes it is bound onto the decoder top module
`timescale 1ns/1ps
module fcw_checker #(
  parameter WD_W = 16
)(
  input wire clk_sys,
  input wire sys_rst,
  input wire [15:0] command_word,
  input wire command_word_valid,
  input wire [1:0] control_place_selection,
  input wire [WD_W-1:0] watchdog_delay_setting,
  input wire jog_enable,
  input wire fault_active,
  input wire [2:0] drive_state_ff,
  input wire run_cmd_ff,
  input wire coast_stop_ff,
  input wire ramp_out_zero_ff,
  input wire ramp_hold_ff,
  input wire jog1_ff,
  input wire jog2_ff,
  input wire fault_ack_ff,
  input wire fb_comm_fault_ff,
  input wire wd_echo_ff
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // word counts only at the fieldbus place with enable set
  wire fb_ok = command_word_valid && control_place_selection == 2'h3 && command_word[10];
  a_coast_inhibit: assert property ((fb_ok && !command_word[1] && !fault_active)[*5]
    |-> drive_state_ff inside {3'h0, 3'h5}) else $error("coast bit did not inhibit");
  a_run_state: assert property (run_cmd_ff |-> drive_state_ff == 3'h3)
    else $error("run flag outside run state");
  a_ramp_prio: assert property (ramp_out_zero_ff |-> !ramp_hold_ff)
    else $error("ramp hold beside ramp zero");
  a_ack_pulse: assert property (fault_ack_ff |=> !fault_ack_ff)
    else $error("acknowledge longer than one cycle");
  a_fault_entry: assert property (fault_active[*3] |-> drive_state_ff == 3'h7)
    else $error("fault not entered");
  a_jog_enable: assert property ($rose(jog1_ff || jog2_ff) |-> $past(jog_enable))
    else $error("jog without enable");
  a_jog_both: assert property (!(jog1_ff && jog2_ff))
    else $error("both jog references active");
  a_drop_coast: assert property (run_cmd_ff && command_word_valid &&
    control_place_selection == 2'h3 && !command_word[10] |-> ##[1:4] coast_stop_ff)
    else $error("enable drop did not coast");
  a_wd_zero: assert property ($rose(fb_comm_fault_ff) |-> $past(watchdog_delay_setting) != 0)
    else $error("watchdog fault with monitoring off");
  a_wd_echo: assert property ((command_word_valid && command_word[11])[*4] |-> wd_echo_ff)
    else $error("watchdog echo missing");
endmodule
bind fieldbus_control_word_decoder fcw_checker #(.WD_W(WD_W)) u_chk (.*);

/* File: verification/cw_master.sv */
// far side model: master that rewrites the command word every cycle
// assumes the bench hands it the word and a watchdog enable
`timescale 1ns/1ps
module cw_master #(
  parameter HALF = 8
)(
  input wire clk_sys,
  input wire [15:0] base_word,
  input wire wd_on,
  output reg [15:0] command_word,
  output reg command_word_valid
);
  reg [7:0] cnt_ff = 8'h00; // cycles in this watchdog half
  reg wd_ff = 1'b0; // watchdog square wave
  initial
  begin
    command_word = 16'h0000;
    command_word_valid = 1'b0;
  end
  // square wave on the watchdog bit, word sent each cycle
  always @(posedge clk_sys)
  begin
    cnt_ff <= (cnt_ff == HALF - 1) ? 8'h00 : cnt_ff + 8'h01;
    if (wd_on && cnt_ff == HALF - 1)
      wd_ff <= ~wd_ff;
    command_word <= #1 {base_word[15:12], wd_ff, base_word[10:0]};
    command_word_valid <= #1 1'b1;
  end
endmodule

/* File: verification/tb.sv */
// self-checking bench for the command word decoder
// assumes the master model and the checker are compiled first
`timescale 1ns/1ps
module tb;
  reg clk_sys = 1'b0; // system clock
  reg sys_rst = 1'b1; // synchronous reset
  reg [15:0] w = 16'h0000; // word handed to the master
  reg wd_on = 1'b0; // watchdog toggling on
  reg [1:0] control_place_selection = 2'h3;
  reg [15:0] watchdog_delay_setting = 16'h0000;
  reg jog_enable = 1'b0, zero_speed = 1'b1, fault_active = 1'b0;
  reg fault_removed_voltage = 1'b1, quick_stop_coasts = 1'b0;
  wire [15:0] command_word;
  wire command_word_valid;
  wire [2:0] drive_state_ff;
  wire run_cmd_ff, coast_stop_ff, ramp_stop_ff, quick_stop_ff, ramp_out_zero_ff;
  wire ramp_hold_ff, ref_zero_ff, jog1_ff, jog2_ff, fault_ack_ff, fb_comm_fault_ff, wd_echo_ff;
  integer fails = 0, cmp_count = 0, i;
  always #2.5 clk_sys = ~clk_sys;
  cw_master #(.HALF(8)) u_master (.clk_sys(clk_sys), .base_word(w), .wd_on(wd_on),
    .command_word(command_word), .command_word_valid(command_word_valid));
  fieldbus_control_word_decoder #(.TICK_CYCLES(4)) DUT (.*);
  // verdict and end of run
  task end_sim;
  begin
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  end
  endtask
  // one comparison
  task ck(input ok);
  begin
    cmp_count = cmp_count + 1;
    if (ok !== 1'b1)
    begin
      fails = fails + 1;
      $display("BAD at %0t: unexpected output", $time);
    end
  end
  endtask
  // present a word for c cycles
  task put(input [15:0] v, input integer c);
  begin
    w = v;
    repeat (c) @(posedge clk_sys);
    #1;
  end
  endtask
  // bounded wait for a state
  task ws(input [2:0] s);
    integer n;
  begin
    n = 0;
    while (drive_state_ff !== s && n < 80)
    begin
      @(posedge clk_sys);
      #1 n = n + 1;
    end
    ck(drive_state_ff === s);
    if (drive_state_ff !== s)
      end_sim;
  end
  endtask
  // inhibit to run
  task up;
  begin
    put(16'h0476, 4);
    put(16'h0477, 2);
    ws(3'h2);
    put(16'h047F, 2);
    ws(3'h3);
  end
  endtask
  initial
  begin
    repeat (8) @(posedge clk_sys);
    #1 sys_rst = 1'b0;
    ck({drive_state_ff, ramp_out_zero_ff, ref_zero_ff, run_cmd_ff} === 6'h06);
    up;
    put(16'hF47F, 8);
    ck(drive_state_ff === 3'h3);
    for (i = 0; i < 3; i = i + 1)
    begin
      put(16'h047F & ~(16'h0010 << i), 6);
      ck({ramp_out_zero_ff, ramp_hold_ff, ref_zero_ff} === (3'b100 >> i));
    end
    zero_speed = 1'b0;
    put(16'h047E, 6);
    ck(ramp_stop_ff === 1'b1);
    zero_speed = 1'b1;
    ws(3'h1);
    put(16'h047F, 2);
    ws(3'h3);
    put(16'h007F, 2);
    ws(3'h0);
    $display("test stops done");
    control_place_selection = 2'h2;
    put(16'h0476, 4);
    put(16'h0477, 8);
    ck(drive_state_ff === 3'h0);
    control_place_selection = 2'h3;
    up;
    put(16'h047D, 2);
    ws(3'h0);
    up;
    zero_speed = 1'b0;
    put(16'h047B, 2);
    ws(3'h6);
    ck(quick_stop_ff === 1'b1);
    zero_speed = 1'b1;
    ws(3'h0);
    fault_active = 1'b1;
    ws(3'h7);
    fault_active = 1'b0;
    put(16'h04F6, 2);
    ws(3'h0);
    put(16'h0476, 4);
    put(16'h0477, 2);
    ws(3'h2);
    jog_enable = 1'b1;
    zero_speed = 1'b0;
    put(16'h050F, 6);
    ck(jog1_ff === 1'b0);
    zero_speed = 1'b1;
    put(16'h050F, 6);
    ck(jog1_ff === 1'b1);
    put(16'h070F, 6);
    ck({jog1_ff, jog2_ff} === 2'b00);
    jog_enable = 1'b0;
    $display("test jog done");
    watchdog_delay_setting = 16'h0005;
    wd_on = 1'b1;
    put(16'h0476, 60);
    ck(fb_comm_fault_ff === 1'b0);
    wd_on = 1'b0;
    put(16'h0476, 60);
    ck(fb_comm_fault_ff === 1'b1);
    watchdog_delay_setting = 16'h0000;
    put(16'h04F6, 4);
    put(16'h0476, 60);
    ck(fb_comm_fault_ff === 1'b0);
    $display("test watchdog done");
    end_sim;
  end
endmodule
